// >>> caf_filter_ctrl.sv
// Control register for acceptance filters sixteen and seventeen.
// Assumes the bus master sits on REF_CLK; matched messages come from same-clock logic.
//
// Overview of operation
// - Enable flag one activates a filter, zero deactivates it.
// - Mask choice 00..11 selects acceptance mask 0..3.
// - Buffer choice routes matched messages to receive FIFO buffer 0..31.
// - Mask and buffer choices change only while the filter is disabled.
// - Filter seventeen: enable bit 15, mask bits 14:13, buffer bits 12:8.
// - Filter sixteen: enable bit 7, mask bits 6:5, buffer bits 4:0.
`timescale 1ns/100ps
module caf_filter_ctrl
   import caf_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic [ADDR_W-1:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA,
   // Per-filter match request from the matching logic
   input wire logic [NUM_FILTERS-1:0] MATCH_IN,
   output logic [NUM_FILTERS-1:0] FILTER_ON,
   output logic [2*NUM_FILTERS-1:0] MASK_CHOICE,
   output logic [NUM_FILTERS-1:0] STORE_VALID,
   output logic [5*NUM_FILTERS-1:0] STORE_BUFFER
);
   caf_bus_type bus;
   caf_slot_type slot [NUM_FILTERS];
   caf_slot_type next_slot [NUM_FILTERS];
   logic [31:0] ctrl_word;
   wire hit = (bus.addr == CTRL4_OFFSET);

   assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

   function automatic caf_slot_type slot_of(input logic [7:0] b);
      slot_of = '{on: b[ON_BIT], mask_choice: b[MASK_HI:MASK_LO],
                  buffer_choice: b[BUF_HI:BUF_LO]};
   endfunction : slot_of

   assign ctrl_word = {16'h0000, slot[1], slot[0]};

   genvar g;
   generate
      for (g = 0; g < NUM_FILTERS; g++) begin : g_filt
         localparam int BASE = (g == 0) ? F16_BASE : F17_BASE;
         wire caf_slot_type wr_slot = slot_of(bus.wdata[BASE +: 8]);
         wire wr_hit = bus.wr && hit;
         // Choices stay frozen while enabled; enable itself is always writable
         assign next_slot[g] = !wr_hit ? slot[g] :
                               slot[g].on ? '{on: wr_slot.on,
                                              mask_choice: slot[g].mask_choice,
                                              buffer_choice: slot[g].buffer_choice}
                                          : wr_slot;

         always_ff @(posedge REF_CLK) begin
            if (RST) begin
               slot[g] <= caf_slot_type'(CTRL4_RESET[BASE +: 8]);
               STORE_VALID[g] <= 1'b0;
               STORE_BUFFER[5*g +: 5] <= 5'h00;
            end else begin
               slot[g] <= next_slot[g];
               STORE_VALID[g] <= MATCH_IN[g] && slot[g].on;
               STORE_BUFFER[5*g +: 5] <= slot[g].buffer_choice;
            end
         end

         always_ff @(posedge REF_CLK) begin
            if (RST) begin
               FILTER_ON[g] <= 1'b0;
               MASK_CHOICE[2*g +: 2] <= 2'h0;
            end else begin
               FILTER_ON[g] <= next_slot[g].on;
               MASK_CHOICE[2*g +: 2] <= next_slot[g].mask_choice;
            end
         end

         locked_hold_a: assert property (@(posedge REF_CLK) disable iff (RST)
            $past(slot[g].on) && !$past(RST) |->
               slot[g].mask_choice == $past(slot[g].mask_choice) &&
               slot[g].buffer_choice == $past(slot[g].buffer_choice))
            else $error("locked filter choice changed");
         off_no_store_a: assert property (@(posedge REF_CLK) disable iff (RST)
            !slot[g].on |=> !STORE_VALID[g])
            else $error("disabled filter stored a message");
         store_route_a: assert property (@(posedge REF_CLK) disable iff (RST)
            MATCH_IN[g] && slot[g].on |=>
               STORE_VALID[g] && STORE_BUFFER[5*g +: 5] == $past(slot[g].buffer_choice))
            else $error("match not routed to chosen buffer");
         open_write_a: assert property (@(posedge REF_CLK) disable iff (RST)
            bus.wr && hit && !slot[g].on |=>
               slot[g] == caf_slot_type'($past(WDATA[BASE +: 8])))
            else $error("write to open filter lost");
         mask_out_a: assert property (@(posedge REF_CLK) disable iff (RST)
            MASK_CHOICE[2*g +: 2] == slot[g].mask_choice)
            else $error("mask choice output wrong");
         enable_write_a: assert property (@(posedge REF_CLK) disable iff (RST)
            bus.wr && hit |=> FILTER_ON[g] == $past(WDATA[BASE + ON_BIT]))
            else $error("enable write not taken");

         // Open filter takes the written mask choice on the next edge
         open_mask_a: assert property (@(posedge REF_CLK) disable iff (RST)
            bus.wr && hit && !slot[g].on |=>
               MASK_CHOICE[2*g +: 2] == $past(WDATA[BASE + MASK_HI -: 2]))
            else $error("open mask choice not taken");

         // Open filter takes the written buffer choice on the next edge
         open_buffer_a: assert property (@(posedge REF_CLK) disable iff (RST)
            bus.wr && hit && !slot[g].on |=>
               slot[g].buffer_choice == $past(WDATA[BASE + BUF_HI -: 5]))
            else $error("open buffer choice not taken");

         // A write that meets an enabled filter must not move its choices
         locked_write_a: assert property (@(posedge REF_CLK) disable iff (RST)
            bus.wr && hit && slot[g].on |=>
               slot[g].mask_choice == $past(slot[g].mask_choice) &&
               slot[g].buffer_choice == $past(slot[g].buffer_choice))
            else $error("locked choice took a write");

         // Clearing the flag is always allowed, even while locked
         locked_clear_a: assert property (@(posedge REF_CLK) disable iff (RST)
            bus.wr && hit && slot[g].on && !WDATA[BASE + ON_BIT] |=>
               !FILTER_ON[g] && !slot[g].on)
            else $error("enable clear refused");

         // Setting the flag from either state
         enable_set_a: assert property (@(posedge REF_CLK) disable iff (RST)
            bus.wr && hit && WDATA[BASE + ON_BIT] |=> slot[g].on && FILTER_ON[g])
            else $error("enable set not taken");

         // No write, no change: unmapped writes and reads leave the slot alone
         idle_hold_a: assert property (@(posedge REF_CLK) disable iff (RST)
            !(bus.wr && hit) |=> slot[g] == $past(slot[g]))
            else $error("filter slot changed without a write");

         // Stores come only from a match request
         no_match_a: assert property (@(posedge REF_CLK) disable iff (RST)
            !MATCH_IN[g] |=> !STORE_VALID[g])
            else $error("store without a match");

         // A store always names the buffer chosen when the match was taken
         store_buffer_a: assert property (@(posedge REF_CLK) disable iff (RST)
            STORE_VALID[g] |->
               STORE_BUFFER[5*g +: 5] == $past(slot[g].buffer_choice))
            else $error("store names wrong buffer");

         // Flag output follows the written enable on an open filter too
         open_enable_a: assert property (@(posedge REF_CLK) disable iff (RST)
            bus.wr && hit && !slot[g].on |=>
               FILTER_ON[g] == $past(WDATA[BASE + ON_BIT]))
            else $error("open enable write lost");

         // Reset leaves every per-filter output quiet; checked while reset is high
         reset_quiet_a: assert property (@(posedge REF_CLK)
            RST |=> !FILTER_ON[g] && !STORE_VALID[g] &&
               MASK_CHOICE[2*g +: 2] == 2'h0 && STORE_BUFFER[5*g +: 5] == 5'h00)
            else $error("filter outputs not cleared by reset");

         // Mask output holds while no write reaches the register
         mask_hold_a: assert property (@(posedge REF_CLK) disable iff (RST)
            !(bus.wr && hit) |=> MASK_CHOICE[2*g +: 2] == $past(MASK_CHOICE[2*g +: 2]))
            else $error("mask choice moved without a write");
      end
   endgenerate

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         RDATA <= UNMAPPED_READ;
      end else if (bus.rd) begin
         RDATA <= hit ? ctrl_word : UNMAPPED_READ;
      end else begin
         RDATA <= UNMAPPED_READ;
      end
   end

   read_back_a: assert property (@(posedge REF_CLK) disable iff (RST)
      RD && hit |=> RDATA == {16'h0000, $past(slot[1]), $past(slot[0])})
      else $error("read data mismatch");
   upper_zero_a: assert property (@(posedge REF_CLK) disable iff (RST)
      RDATA[31:16] == 16'h0000)
      else $error("upper bits not zero");

   // Read data stand only in the cycle after the strobe
   rdata_idle_a: assert property (@(posedge REF_CLK) disable iff (RST)
      !RD |=> RDATA == UNMAPPED_READ)
      else $error("read data outside read cycle");

   // Unmapped reads return the idle word
   unmapped_read_a: assert property (@(posedge REF_CLK) disable iff (RST)
      RD && !hit |=> RDATA == UNMAPPED_READ)
      else $error("unmapped read not idle");

   // Unmapped writes must not reach either filter
   unmapped_write_a: assert property (@(posedge REF_CLK) disable iff (RST)
      WR && !hit |=> slot[0] == $past(slot[0]) && slot[1] == $past(slot[1]))
      else $error("unmapped write changed a filter");

   // Low byte read back against the flag and mask outputs
   read_low_a: assert property (@(posedge REF_CLK) disable iff (RST)
      RD && hit |=>
         RDATA[F16_BASE + ON_BIT] == $past(FILTER_ON[0]) &&
         RDATA[F16_BASE + MASK_HI -: 2] == $past(MASK_CHOICE[1:0]))
      else $error("filter sixteen read back wrong");

   // Second byte read back against the flag and mask outputs
   read_high_a: assert property (@(posedge REF_CLK) disable iff (RST)
      RD && hit |=>
         RDATA[F17_BASE + ON_BIT] == $past(FILTER_ON[1]) &&
         RDATA[F17_BASE + MASK_HI -: 2] == $past(MASK_CHOICE[3:2]))
      else $error("filter seventeen read back wrong");

   // Reset clears read data and the register
   reset_rdata_a: assert property (@(posedge REF_CLK)
      RST |=> RDATA == UNMAPPED_READ && ctrl_word == CTRL4_RESET)
      else $error("reset did not clear register");

   // Strobes never overlap; the slave would serve both silently, reading back the pre-write word
   strobe_excl_a: assert property (@(posedge REF_CLK) disable iff (RST)
      RD && hit |=> RDATA[31:16] == 16'h0000 && $past(!WR))
      else $error("read overlapped a write");
endmodule : caf_filter_ctrl

// >>> caf_msg_src.sv
// Far-side model: a message source raising per-filter match pulses.
// Assumes the bench asks for a match with a one-cycle go pulse.
`timescale 1ns/100ps
module caf_msg_src (
   input wire logic clk,
   input wire logic [1:0] go,
   output logic [1:0] match
);
   always_ff @(posedge clk) begin
      match <= go;
   end
endmodule : caf_msg_src

// >>> caf_pkg.sv
// Package for the acceptance filter control block: offsets, field layout, reset values.
// Assumes a plain address/strobe register port with 32-bit data.
package caf_pkg;
   localparam int ADDR_W = 4;
   localparam logic [ADDR_W-1:0] CTRL4_OFFSET = 4'h0;
   localparam logic [31:0] CTRL4_RESET = 32'h0000_0000;
   localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
   // Field positions inside each filter byte
   localparam int ON_BIT = 7;
   localparam int MASK_HI = 6;
   localparam int MASK_LO = 5;
   localparam int BUF_HI = 4;
   localparam int BUF_LO = 0;
   // Byte lane of each filter
   localparam int F16_BASE = 0;
   localparam int F17_BASE = 8;
   localparam int NUM_FILTERS = 2;

   typedef struct packed {
      logic on;
      logic [1:0] mask_choice;
      logic [4:0] buffer_choice;
   } caf_slot_type;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } caf_bus_type;
endpackage : caf_pkg

// >>> can_acceptance_filter_ctrl_tb.sv
// Bench for the filter control block: access, lock, routing.
// Assumes caf_pkg and caf_msg_src come first.
`timescale 1ns/100ps
module can_acceptance_filter_ctrl_tb;
   import caf_pkg::*;
   logic REF_CLK = 1'b0, RST = 1'b1, WR = 1'b0, RD = 1'b0, rd_d = 1'b0;
   logic [ADDR_W-1:0] ADDR = 4'h0;
   logic [31:0] WDATA = 32'h0, RDATA, seed = 32'hB202, r, w;
   logic [1:0] go = 2'h0, MATCH_IN, FILTER_ON, STORE_VALID;
   logic [3:0] MASK_CHOICE;
   logic [9:0] STORE_BUFFER;
   logic [31:0] rq[$];
   logic [11:0] sq[$];
   int n_errors = 0, checked = 0;
   always #4 REF_CLK = ~REF_CLK;
   caf_msg_src src (.clk(REF_CLK), .go(go), .match(MATCH_IN));
   caf_filter_ctrl dut (.REF_CLK(REF_CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
      .WR(WR), .RD(RD), .RDATA(RDATA), .MATCH_IN(MATCH_IN), .FILTER_ON(FILTER_ON),
      .MASK_CHOICE(MASK_CHOICE), .STORE_VALID(STORE_VALID), .STORE_BUFFER(STORE_BUFFER));
   task automatic cmp(string nm, logic [31:0] e, logic [31:0] s);
      checked++;
      if (s !== e) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask : cmp
   task automatic acc(logic we, logic [3:0] a, logic [31:0] d);
      if (!we) rq.push_back(d);
      @(posedge REF_CLK);
      {WR, RD, ADDR, WDATA} <= {we, !we, a, d};
      @(posedge REF_CLK);
      {WR, RD} <= 2'h0;
   endtask : acc
   task automatic fire(logic [11:0] e);
      if (e !== 12'h0) sq.push_back(e);
      @(posedge REF_CLK);
      go <= 2'h3;
      @(posedge REF_CLK);
      go <= 2'h0;
      repeat (3) @(posedge REF_CLK);
   endtask : fire
   // Unexpected stores pop an empty queue and so mismatch
   always @(posedge REF_CLK) begin
      rd_d <= RD;
      if (rd_d) cmp("rdata", rq.pop_front(), RDATA);
      if (STORE_VALID !== 2'h0)
         cmp("store", {20'h0, sq.pop_front()}, {20'h0, STORE_VALID, STORE_BUFFER});
   end
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : tally_and_finish
   initial begin
      #20000;
      n_errors++;
      tally_and_finish();
   end
   initial begin
      repeat (10) @(posedge REF_CLK);
      RST <= 1'b0;
      acc(1'b0, 4'h0, 32'h0);
      for (int m = 0; m < 4; m++) begin
         r = $random(seed);
         w = {16'h0, 1'b0, 2'(3 - m), r[12:8], 1'b0, 2'(m), r[4:0]};
         acc(1'b1, 4'h0, w);
         fire(12'h0);
         acc(1'b1, 4'h0, w | 32'h8080);
         acc(1'b0, 4'h0, w | 32'h8080);
         cmp("mask", {26'h0, 2'h3, 2'(3 - m), 2'(m)}, {26'h0, FILTER_ON, MASK_CHOICE});
         fire({2'h3, r[12:8], r[4:0]});
         acc(1'b1, 4'h0, (w ^ 32'h7F7F) | 32'h8080);
         acc(1'b0, 4'h0, w | 32'h8080);
         acc(1'b1, 4'h0, 32'h0);
         acc(1'b0, 4'h0, w);
         fire(12'h0);
         acc(1'b1, 4'h0, 32'h0);
         acc(1'b0, 4'h0, 32'h0);
         $display("test %0d done", m);
      end
      acc(1'b1, 4'h1, 32'hFFFF_FFFF);
      acc(1'b0, 4'h1, 32'h0);
      acc(1'b0, 4'h0, 32'h0);
      tally_and_finish();
   end
endmodule : can_acceptance_filter_ctrl_tb
